// ---- sim/adram_mem_model.sv ----
// behavioural bank of four strobe-addressed memory modules
// assumes the bench resolves the shared data lines from both drivers
`timescale 1ns/10ps
`default_nettype none
module adram_mem_model (
  // pins from the controller, the shared data lines and the bench's slowMode select
  input wire adram_pkg::adram_pins_t pins,
  input wire logic [7:0] dataWire,
  input wire logic slowMode,
  // read drive and rule breaches seen
  output logic [7:0] memQ,
  output logic memQEnN,
  output int violations
);
  import adram_pkg::*;
  logic [7:0] mem [int];
  logic [7:0] rowQ;
  logic [3:0] casPrev;
  realtime rasFallT;
  int rasCount;
  initial begin
    memQ = 8'h00;
    memQEnN = 1'b1;
    violations = 0;
    rasCount = 0;
    casPrev = 4'hF;
  end
  // row latched at the fall; a row-only cycle refreshes it
  always @(negedge pins.rowStrobeN) begin
    rowQ = pins.muxedAddressBus;
    rasFallT = $realtime;
    rasCount++;
  end
  // a late write would fight our outputs on the shared lines
  always @(negedge pins.writeEnableN) if (pins.colStrobeN !== 4'hF) violations++;
  // outputs stay off unless a column strobe is low
  always @(pins.colStrobeN) begin
    // look just after the edge, inside the hold window, once same-edge updates settle
    #1;
    for (int m = 0; m < 4; m++) begin
      if (casPrev[m] && !pins.colStrobeN[m]) colFall(m);
      if (!casPrev[m] && pins.colStrobeN[m]) memQEnN = 1'b1;
    end
    casPrev = pins.colStrobeN;
  end
  // early write latches at the fall; read drives after the access time
  task automatic colFall(input int m);
    int a;
    a = {m[1:0], rowQ, pins.muxedAddressBus};
    if (rasCount < 8 || pins.rowStrobeN || $realtime - rasFallT < 30.0) violations++;
    if (!pins.writeEnableN) mem[a] = dataWire;
    else fork
      begin
        #(slowMode ? 70 : 20);
        if (!pins.colStrobeN[m]) begin
          memQ = mem.exists(a) ? mem[a] : 8'h00;
          memQEnN = 1'b0;
        end
      end
    join_none
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the strobe-driven memory controller
// assumes the controller and the memory bank model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import adram_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic reqValid = 1'b0;
  logic reqPageLast = 1'b1;
  logic slowMode = 1'b0;
  adram_req_t req = '0;
  logic reqReady, rdValid, initDone, dataOutEnN, memQEnN;
  logic [7:0] rdData, dataOut, memQ;
  logic [7:0] lastWire = 8'h00;
  wire logic [7:0] dataWire;
  adram_pins_t pins;
  int violations, failures = 0, compares = 0, rasFalls = 0, firstRasNs = 0, cyc = 0;
  int lastRef = 0, refCount = 0, refLate = 0, casInLow = 0, driveInLow = 0;
  // released lines show a changing pattern, never the last driven value
  assign dataWire = !dataOutEnN ? dataOut : (!memQEnN ? memQ : ~lastWire);
  always @(posedge sys_clk) lastWire <= dataWire;
  always @(posedge sys_clk) cyc <= cyc + 1;
  always #5 sys_clk = ~sys_clk;
  adram_ctrl dut_u (.sys_clk(sys_clk), .reset(reset), .reqValid(reqValid), .req(req), .reqPageLast(reqPageLast),
    .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData), .initDone(initDone), .pins(pins), .dataIn(dataWire),
    .dataOut(dataOut), .dataOutEnN(dataOutEnN));
  adram_mem_model mem_u (.pins(pins), .dataWire(dataWire), .slowMode(slowMode), .memQ(memQ), .memQEnN(memQEnN),
    .violations(violations));
  task automatic oops(input string msg);
    failures++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask
  task automatic checkData(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) oops($sformatf("data %h, expected %h", got, exp));
  endtask
  task automatic checkCount(input int got, input int exp);
    compares++;
    if (got != exp) oops($sformatf("count %0d, expected %0d", got, exp));
  endtask
  // row strobe watch; a low period with no column strobe is a refresh
  always @(negedge pins.rowStrobeN) begin
    if (rasFalls == 0) firstRasNs = $time;
    rasFalls++;
    casInLow = 0;
    driveInLow = 0;
  end
  always @(negedge sys_clk) begin
    if (!pins.rowStrobeN && pins.colStrobeN !== 4'hF) casInLow = 1;
    if (!pins.rowStrobeN && (dataOutEnN === 1'b0 || memQEnN === 1'b0)) driveInLow = 1;
    if (dataOutEnN === 1'b0 && memQEnN === 1'b0) oops("both ends drive the data lines");
  end
  always @(posedge pins.rowStrobeN) if (initDone === 1'b1 && casInLow == 0) begin
    checkCount(driveInLow, 0);
    if (cyc - lastRef > 1562) refLate++;
    lastRef = cyc;
    refCount++;
  end
  // one request: hold until taken, then wait a bounded time for read data, or for a write's column strobe to end
  task automatic access(input logic wr, input logic [1:0] sel, input logic [7:0] row, input logic [5:0] col,
                        input logic [7:0] wd, input logic last, output logic [7:0] rd);
    int n;
    @(posedge sys_clk);
    reqValid <= 1'b1;
    req <= '{write: wr, module_sel: sel, row: row, col: col, wdata: wd};
    reqPageLast <= last;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (reqReady !== 1'b1 && n < 3000);
    @(posedge sys_clk);
    reqValid <= 1'b0;
    rd = 8'h00;
    n = 0;
    // a write stays until its column strobe ends, where the row-close flag is sampled
    if (wr) begin
      do begin @(negedge sys_clk); n++; end while (pins.colStrobeN === 4'hF && n < 100);
      do begin @(negedge sys_clk); n++; end while (pins.colStrobeN !== 4'hF && n < 100);
    end else begin
      do begin @(negedge sys_clk); n++; end while (rdValid !== 1'b1 && n < 100);
      rd = rdData;
    end
    if (n >= 100) oops("access did not finish");
  endtask
  task automatic s_init();
    int n;
    n = 0;
    while (initDone !== 1'b1 && n < 12000) begin
      @(negedge sys_clk);
      n++;
    end
    checkCount(int'(firstRasNs >= 100055), 1);
    checkCount(rasFalls, 8);
    lastRef = cyc;
  endtask
  // same column in all four modules proves the strobe decode
  task automatic s_modules();
    logic [7:0] rd;
    for (int m = 0; m < 4; m++) access(1'b1, m[1:0], 8'hA5, 6'h2A, 8'h3C ^ 8'(m), 1'b1, rd);
    for (int m = 0; m < 4; m++) begin
      slowMode <= m[0];
      access(1'b0, m[1:0], 8'hA5, 6'h2A, 8'h00, 1'b1, rd);
      checkData(rd, 8'h3C ^ 8'(m));
    end
  endtask
  // bursts start just after a refresh so no refresh splits them
  task automatic s_page();
    logic [7:0] rd;
    int r0, ref0;
    ref0 = refCount;
    while (refCount == ref0) @(negedge sys_clk);
    r0 = rasFalls;
    for (int i = 0; i < 4; i++) access(1'b1, i[1:0], 8'h17, 6'(i * 21), 8'hC0 + 8'(i), i == 3, rd);
    for (int i = 0; i < 4; i++) begin
      access(1'b0, i[1:0], 8'h17, 6'(i * 21), 8'h00, i == 3, rd);
      checkData(rd, 8'hC0 + 8'(i));
    end
    checkCount(rasFalls - r0, 2);
  endtask
  task automatic s_refresh();
    int ref0;
    ref0 = refCount;
    repeat (3200) @(posedge sys_clk);
    checkCount(int'(refCount - ref0 >= 2), 1);
    checkCount(refLate, 0);
    checkCount(violations, 0);
  endtask
  task automatic print_verdict();
    $display("compares %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    s_init();
    s_modules();
    s_page();
    s_refresh();
    print_verdict();
  end
  // hang guard, well beyond the expected run of about 14300 cycles
  initial begin
    #400000;
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- src/adram_consts.svh ----
// timing counts and field sizes for the strobe-driven memory controller
// assumes a 100 MHz sys_clk (10 ns period)
`ifndef ADRAM_CONSTS_SVH
`define ADRAM_CONSTS_SVH
`define ADRAM_CLK_NS 10
// row-strobe low to column-strobe low, least 30 ns, cycles rounded up
`define ADRAM_RCD_NS 30
`define ADRAM_RCD_CYC ((`ADRAM_RCD_NS + `ADRAM_CLK_NS - 1) / `ADRAM_CLK_NS)
// column-strobe low width, least 70 ns; also covers column access time
`define ADRAM_CAS_NS 70
`define ADRAM_CAS_CYC ((`ADRAM_CAS_NS + `ADRAM_CLK_NS - 1) / `ADRAM_CLK_NS)
// column-strobe precharge in page mode, least 40 ns
`define ADRAM_CP_NS 40
`define ADRAM_CP_CYC ((`ADRAM_CP_NS + `ADRAM_CLK_NS - 1) / `ADRAM_CLK_NS)
// page cycle least 120 ns
`define ADRAM_PC_NS 120
`define ADRAM_PC_CYC ((`ADRAM_PC_NS + `ADRAM_CLK_NS - 1) / `ADRAM_CLK_NS)
// row-strobe low least 120 ns, high (precharge) least 80 ns
`define ADRAM_RAS_NS 120
`define ADRAM_RAS_CYC ((`ADRAM_RAS_NS + `ADRAM_CLK_NS - 1) / `ADRAM_CLK_NS)
`define ADRAM_RP_NS 80
`define ADRAM_RP_CYC ((`ADRAM_RP_NS + `ADRAM_CLK_NS - 1) / `ADRAM_CLK_NS)
// power-up hold of row strobe high, 100 us
`define ADRAM_PWR_US 100
`define ADRAM_PWR_CYC (`ADRAM_PWR_US * 1000 / `ADRAM_CLK_NS)
`define ADRAM_INIT_CYCLES 8
// refresh: 256 rows within 4 ms, so one row each 4 ms / 256, rounded down
`define ADRAM_REF_MS 4
`define ADRAM_ROWS 256
`define ADRAM_REF_CYC (`ADRAM_REF_MS * 1000000 / `ADRAM_CLK_NS / `ADRAM_ROWS)
`define ADRAM_PAGE_COLS 64
`define ADRAM_ROW_W 8
`define ADRAM_COL_W 6
`define ADRAM_DATA_W 8
`define ADRAM_NMOD 4
`endif

// ---- src/adram_counter.sv ----
// down-counter used for every strobe delay of the controller
// assumes load and count come from logic on sys_clk
`timescale 1ns/10ps
`default_nettype none
module adram_counter (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // control
  input wire logic load,
  input wire logic [23:0] loadValue,
  // status
  output logic done
);
  logic [23:0] count_q;
  // reloads on load, otherwise runs down and sticks at zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_q <= 24'h000000;
    end else if (load) begin
      count_q <= loadValue;
    end else if (count_q != 24'h000000) begin
      count_q <= count_q - 24'h000001;
    end
  end
  // done looks at the count only, so a caller that reloads on done forms no loop
  assign done = (count_q == 24'h000000);
endmodule
`default_nettype wire

// ---- src/adram_ctrl.sv ----
// controller that drives a bank of strobe-addressed dynamic memory modules
// assumes modules share row strobe and address; one column strobe per module
`timescale 1ns/10ps
`default_nettype none
`include "adram_consts.svh"
module adram_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // user request port
  input wire logic reqValid,
  input wire adram_pkg::adram_req_t req,
  input wire logic reqPageLast,
  output logic reqReady,
  output logic rdValid,
  output logic [`ADRAM_DATA_W-1:0] rdData,
  output logic initDone,
  // memory pins
  output adram_pkg::adram_pins_t pins,
  input wire logic [`ADRAM_DATA_W-1:0] dataIn,
  output logic [`ADRAM_DATA_W-1:0] dataOut,
  output logic dataOutEnN
);
  import adram_pkg::*;

  adram_state_t state_q;
  adram_req_t cur_q;
  logic [7:0] initCnt_q, refRow_q;
  logic [6:0] pageCnt_q;
  logic refPend_q, pageOpen_q, pwrLoaded_q, dly_ld, ref_ld;
  logic [23:0] dly_val;
  logic dlyDone, refTick;
  logic [`ADRAM_DATA_W-1:0] dq1_q, dq2_q;

  function automatic logic [23:0] cyc(input int n);
    cyc = 24'(n);
  endfunction

  // a page continuation needs the open row and the same access kind
  function automatic logic pageHit(input adram_req_t r, input adram_req_t c);
    pageHit = (r.row == c.row) && (r.write == c.write);
  endfunction

  // strobe delay timer
  adram_counter u_dly (.sys_clk(sys_clk), .reset(reset), .load(dly_ld), .loadValue(dly_val), .done(dlyDone));
  // refresh interval timer, one row per tick
  adram_counter u_ref (.sys_clk(sys_clk), .reset(reset), .load(ref_ld), .loadValue(cyc(`ADRAM_REF_CYC - 1)),
    .done(refTick));
  assign ref_ld = refTick;

  // refresh request is sticky; a new tick wins over the clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      refPend_q <= 1'b0;
    end else if (refTick && initDone) begin
      refPend_q <= 1'b1;
    end else if (state_q == ST_REFLO && dlyDone) begin
      refPend_q <= 1'b0;
    end
  end

  // data line synchroniser: pins are another domain
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dq1_q <= 8'h00;
      dq2_q <= 8'h00;
    end else begin
      dq1_q <= dataIn;
      dq2_q <= dq1_q;
    end
  end

  assign reqReady = initDone && !refPend_q &&
    ((state_q == ST_IDLE) || (state_q == ST_CASHI && pageOpen_q && dlyDone && pageHit(req, cur_q)));

  // main sequencer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_POWER;
      cur_q <= '0;
      initCnt_q <= 8'h00;
      refRow_q <= 8'h00;
      pageCnt_q <= 7'h00;
      pageOpen_q <= 1'b0;
      initDone <= 1'b0;
      rdValid <= 1'b0;
      rdData <= 8'h00;
      pins <= '{rowStrobeN: 1'b1, colStrobeN: 4'hF, writeEnableN: 1'b1, muxedAddressBus: 8'h00};
      dataOut <= 8'h00;
      dataOutEnN <= 1'b1;
    end else begin
      rdValid <= 1'b0;
      unique case (state_q)
        ST_POWER: if (dlyDone && pwrLoaded_q) begin
          pins.rowStrobeN <= 1'b0;
          pins.muxedAddressBus <= refRow_q;
          state_q <= ST_REFLO;
        end
        ST_IDLE: if (refPend_q) begin
          pins.rowStrobeN <= 1'b0;
          pins.muxedAddressBus <= refRow_q;
          state_q <= ST_REFLO;
        end else if (reqValid) begin
          cur_q <= req;
          pins.rowStrobeN <= 1'b0;
          pins.muxedAddressBus <= req.row;
          pins.writeEnableN <= !req.write;
          dataOut <= req.wdata;
          dataOutEnN <= !req.write;
          pageCnt_q <= 7'h00;
          state_q <= ST_RCD;
        end
        ST_RCD: if (dlyDone) begin
          pins.muxedAddressBus <= {2'b00, cur_q.col};
          pins.colStrobeN[cur_q.module_sel] <= 1'b0;
          state_q <= ST_CASLO;
        end
        ST_CASLO: if (dlyDone) begin
          if (!cur_q.write) begin
            rdData <= dq2_q;
            rdValid <= 1'b1;
          end
          pins.colStrobeN <= 4'hF;
          pageOpen_q <= !reqPageLast && (pageCnt_q < 7'(`ADRAM_PAGE_COLS - 1));
          state_q <= ST_CASHI;
        end
        ST_CASHI: if (dlyDone) begin
          if (pageOpen_q && reqValid && !refPend_q && pageHit(req, cur_q)) begin
            // column and data go out a cycle before the strobe falls, for data setup
            cur_q <= req;
            dataOut <= req.wdata;
            pageCnt_q <= pageCnt_q + 7'h01;
            pins.muxedAddressBus <= {2'b00, req.col};
            state_q <= ST_RCD;
          end else begin
            pins.rowStrobeN <= 1'b1;
            pins.writeEnableN <= 1'b1;
            dataOutEnN <= 1'b1;
            pageOpen_q <= 1'b0;
            state_q <= ST_RASHI;
          end
        end
        ST_REFLO: if (dlyDone) begin
          pins.rowStrobeN <= 1'b1;
          refRow_q <= refRow_q + 8'h01;
          if (!initDone) begin
            initCnt_q <= initCnt_q + 8'h01;
          end
          state_q <= ST_RASHI;
        end
        ST_RASHI: if (dlyDone) begin
          if (initCnt_q == 8'(`ADRAM_INIT_CYCLES)) begin
            initDone <= 1'b1;
          end
          state_q <= (initDone || initCnt_q == 8'(`ADRAM_INIT_CYCLES)) ? ST_IDLE : ST_POWER;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // delay loads on each state change but the return to idle; hold RAS wide enough for page cycle too
  always_comb begin
    dly_ld = 1'b0;
    dly_val = 24'h000000;
    unique case (state_q)
      ST_IDLE: begin
        dly_ld = refPend_q || reqValid;
        dly_val = refPend_q ? cyc(`ADRAM_RAS_CYC - 1) : cyc(`ADRAM_RCD_CYC - 1);
      end
      ST_RCD: begin
        dly_ld = dlyDone;
        dly_val = cyc(`ADRAM_CAS_CYC + 2); // two extra cycles carry read data through the two-flop sync
      end
      ST_CASLO: begin
        dly_ld = dlyDone;
        dly_val = cyc(`ADRAM_CP_CYC - 1); // column precharge; the page cycle then exceeds its minimum
      end
      ST_CASHI: begin
        dly_ld = dlyDone;
        dly_val = cyc(`ADRAM_RP_CYC - 1);
        if (pageOpen_q && reqValid && !refPend_q && pageHit(req, cur_q)) begin
          dly_val = 24'h000000; // one setup cycle before the column strobe falls
        end
      end
      ST_REFLO: begin
        dly_ld = dlyDone;
        dly_val = cyc(`ADRAM_RP_CYC - 1);
      end
      ST_RASHI: begin
        dly_ld = dlyDone && !initDone && initCnt_q != 8'(`ADRAM_INIT_CYCLES);
        dly_val = 24'h000000;
      end
      ST_POWER: begin
        dly_ld = !pwrLoaded_q || dlyDone;
        // first the long wait, then the row-strobe low width of each start-up cycle
        dly_val = pwrLoaded_q ? cyc(`ADRAM_RAS_CYC - 1) : cyc(`ADRAM_PWR_CYC - 1);
      end
      default: begin
        dly_ld = 1'b0;
      end
    endcase
  end

  // power-up wait is loaded once, in the first cycle after reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pwrLoaded_q <= 1'b0;
    end else begin
      pwrLoaded_q <= 1'b1;
    end
  end

  // row strobe stays high through the whole power-up wait
  a_power_ras_high: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == ST_POWER && initCnt_q == 8'h00) |-> pins.rowStrobeN) else $error("row strobe low during power-up");
  // column strobes never fall during refresh
  a_refresh_no_cas: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == ST_REFLO) |-> (pins.colStrobeN == 4'hF && dataOutEnN)) else $error("column strobe in refresh");
  // write enable low before any column strobe falls in a write
  a_early_write: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(pins.colStrobeN != 4'hF) && !pins.writeEnableN |-> $past(!pins.writeEnableN)) else $error("late write");
  // row-to-column delay meets 3 cycles
  sequence s_ras_fall;
    $fell(pins.rowStrobeN) && state_q == ST_RCD;
  endsequence
  a_rcd_delay: assert property (@(posedge sys_clk) disable iff (reset)
    s_ras_fall |-> (pins.colStrobeN == 4'hF) [*3]) else $error("row-to-column delay short");
  // controller never drives data during a read
  a_read_release: assert property (@(posedge sys_clk) disable iff (reset)
    (!pins.rowStrobeN && pins.writeEnableN) |-> dataOutEnN) else $error("data driven in read");
  // column strobe low holds at least seven cycles
  a_cas_width: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(pins.colStrobeN != 4'hF) |-> (pins.colStrobeN != 4'hF) [*7]) else $error("column strobe short");
  // refresh request is served within a bounded time
  a_refresh_served: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(refPend_q) |-> ##[1:400] !refPend_q) else $error("refresh missed");
  // row strobe precharge at least eight cycles
  a_ras_precharge: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(pins.rowStrobeN) |-> pins.rowStrobeN [*8]) else $error("row precharge short");
endmodule
`default_nettype wire

// ---- src/adram_pkg.sv ----
// types shared by the strobe-driven memory controller
// assumes adram_consts.svh is on the include path
`include "adram_consts.svh"
package adram_pkg;
  // one user request: module select, row, column, write data
  typedef struct packed {
    logic write;
    logic [1:0] module_sel;
    logic [`ADRAM_ROW_W-1:0] row;
    logic [`ADRAM_COL_W-1:0] col;
    logic [`ADRAM_DATA_W-1:0] wdata;
  } adram_req_t;
  // pin group driven toward the memory modules
  typedef struct packed {
    logic rowStrobeN;
    logic [`ADRAM_NMOD-1:0] colStrobeN;
    logic writeEnableN;
    logic [`ADRAM_ROW_W-1:0] muxedAddressBus;
  } adram_pins_t;
  typedef enum logic [2:0] {
    ST_POWER = 3'b000,
    ST_IDLE = 3'b001,
    ST_RCD = 3'b010,
    ST_CASLO = 3'b011,
    ST_CASHI = 3'b100,
    ST_RASHI = 3'b101,
    ST_REFLO = 3'b110
  } adram_state_t;
endpackage
